// ===== hw/nidsd_pkg.sv
// Package: constants and types for the node ID and status display block
package nidsd_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_BASE_ADDR = 8'h04;
  localparam logic [7:0] REG_DEFAULT_ADDR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_HIST_SEL = 8'h10;
  localparam logic [7:0] REG_HIST_DATA = 8'h14;
  // Config register fields
  localparam int CFG_LINE2_BIT = 0;
  localparam int CFG_RATE_LSB = 4;
  // Status register fields
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_ID_MODE_BIT = 8;
  localparam int ST_FAULT_BIT = 9;
  localparam int ST_ACTIVE_ERR_BIT = 10;
  localparam int ST_INIT_BIT = 11;
  localparam int ST_RATE_LSB = 12;
  localparam int ST_LINE2_BIT = 15;
  localparam int ST_WCOUNT_LSB = 16;
  localparam int ST_ECOUNT_LSB = 20;
  // Reset values
  localparam logic [7:0] BASE_ADDR_RESET = 8'h64;
  localparam logic [7:0] DEFAULT_ADDR_RESET = 8'h64;
  localparam logic LINE2_RESET = 1'b1;
  // Bit rate codes: 50, 125, 250, 500, 1000 kBaud
  typedef enum logic [2:0] {
    RATE_50K = 3'b000,
    RATE_125K = 3'b001,
    RATE_250K = 3'b010,
    RATE_500K = 3'b011,
    RATE_1000K = 3'b100
  } nidsd_rate_type;
  localparam logic [2:0] RATE_RESET = 3'h3;
  localparam logic [2:0] RATE_MAX = 3'h4;
  // ID assignment frame
  localparam logic [10:0] ID_FRAME_COBID = 11'h7f2;
  localparam logic [3:0] SWITCH_MAX = 4'h9;
  // Event history depth per type
  localparam int HIST_DEPTH = 6;
  localparam logic [15:0] MISSING_PARAM_FILE_CODE = 16'h0002;
  // Display views
  typedef enum logic [1:0] {
    VIEW_ADDR = 2'b00,
    VIEW_WARN = 2'b01,
    VIEW_ERR = 2'b10
  } nidsd_view_type;
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int DEBOUNCE_MS = 10;
  localparam int HOLD_MS = 3000;
  localparam int BLINK_HALF_MS = 250;
  localparam int DEBOUNCE_CYCLES = CLK_KHZ * DEBOUNCE_MS;
  localparam int HOLD_CYCLES = CLK_KHZ * HOLD_MS;
  localparam int BLINK_HALF_CYCLES = CLK_KHZ * BLINK_HALF_MS;
endpackage

// ===== hw/nidsd_top.sv
// Module: node ID selection, settings registers, LEDs and status display
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module nidsd_top #(
  parameter int DEBOUNCE_CYC = nidsd_pkg::DEBOUNCE_CYCLES,
  parameter int HOLD_CYC = nidsd_pkg::HOLD_CYCLES,
  parameter int BLINK_CYC = nidsd_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Front panel pins
  input wire logic [3:0] id_switch_i,
  input wire logic button_i,
  input wire logic param_file_present_i,
  input wire logic param_load_done_i,
  // Received frames and network management
  input wire logic frame_valid_i,
  input wire logic [10:0] frame_cobid_i,
  input wire logic [47:0] frame_data_i,
  input wire logic nmt_reset_i,
  // Events
  input wire logic event_valid_i,
  input wire logic event_is_error_i,
  input wire logic event_preop_i,
  input wire logic [15:0] event_code_i,
  // Line status
  input wire logic [1:0] line_activity_i,
  input wire logic [1:0] line_error_i,
  // Bus controller settings
  output logic [7:0] node_address_o,
  output nidsd_pkg::nidsd_rate_type bus_bit_rate_o,
  output logic second_line_enable_o,
  output logic bus_comm_enable_o,
  output logic id_setting_mode_o,
  // Nonvolatile store request
  output logic store_default_o,
  output logic [7:0] store_default_addr_o,
  // Emergency and state change requests
  output logic emergency_o,
  output logic [15:0] emergency_code_o,
  output logic nmt_preop_o,
  // LEDs
  output logic run_led_green_o,
  output logic run_led_red_o,
  output logic [1:0] line_led_green_o,
  output logic [1:0] line_led_red_o,
  // Seven segment display
  output logic [15:0] seg_digits_o,
  output logic seg_blank_o,
  output logic seg_dot_warn_o,
  output logic seg_dot_err_o
);
  import nidsd_pkg::*;

  function automatic logic [11:0] to_decimal(input logic [7:0] v);
    logic [3:0] h;
    logic [3:0] t;
    logic [3:0] u;
    h = 4'(v / 8'd100);
    t = 4'((v % 8'd100) / 8'd10);
    u = 4'(v % 8'd10);
    return {h, t, u};
  endfunction

  function automatic logic [2:0] count_up(input logic [2:0] c);
    return (c == 3'(HIST_DEPTH)) ? c : c + 3'h1;
  endfunction

  // Input synchronisers
  logic [3:0] sw_meta, sw_sync;
  // Switch word taken only once two samples agree
  logic [3:0] sw_prev, sw_val;
  logic btn_meta, btn_sync;
  logic pf_meta, pf_sync;
  logic pl_meta, pl_sync;
  always_ff @(posedge clk_i) begin
    sw_meta <= id_switch_i;
    sw_sync <= sw_meta;
    sw_prev <= sw_sync;
    if (sw_sync == sw_prev) begin
      sw_val <= sw_sync;
    end
    btn_meta <= button_i;
    btn_sync <= btn_meta;
    pf_meta <= param_file_present_i;
    pf_sync <= pf_meta;
    pl_meta <= param_load_done_i;
    pl_sync <= pl_meta;
  end

  // Button debounce and hold timer
  logic btn_state;
  logic [31:0] deb_cnt;
  logic [31:0] hold_cnt;
  wire btn_differs = btn_sync != btn_state;
  wire deb_done = btn_differs && (deb_cnt == 32'(DEBOUNCE_CYC - 1));
  wire press = deb_done && !btn_state;
  wire hold_hit = btn_state && (hold_cnt == 32'(HOLD_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_state <= 1'b0;
      deb_cnt <= 32'h0;
      hold_cnt <= 32'h0;
    end else begin
      deb_cnt <= (btn_differs && !deb_done) ? deb_cnt + 32'h1 : 32'h0;
      if (deb_done) begin
        btn_state <= btn_sync;
      end
      hold_cnt <= (btn_state && !hold_hit && !deb_done) ? hold_cnt + 32'h1 : 32'h0;
    end
  end

  // Common blink source
  logic [31:0] blink_cnt;
  logic blink;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt <= 32'h0;
      blink <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
      blink_cnt <= 32'h0;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // Settings registers
  logic [7:0] base_node_address;
  logic [7:0] default_node_address;
  logic second_line_enable;
  logic [2:0] bus_bit_rate_setting;
  logic [3:0] hist_sel;
  logic initialising;
  logic param_fault;
  logic id_mode;
  logic [7:0] pending_addr;
  logic active_error;
  logic wb_ack;

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire wr_config = wb_wr && (wb_adr_i == REG_CONFIG);
  wire wr_base = wb_wr && (wb_adr_i == REG_BASE_ADDR);
  wire wr_default = wb_wr && (wb_adr_i == REG_DEFAULT_ADDR);
  wire wr_hist_sel = wb_wr && (wb_adr_i == REG_HIST_SEL);
  wire [2:0] wr_rate = wb_dat_i[CFG_RATE_LSB +: 3];
  wire restart = rst_i || nmt_reset_i;

  // Node address selection
  wire sw_zero = (sw_val == 4'h0) || (sw_val > SWITCH_MAX);
  wire [7:0] next_node_address = sw_zero ? default_node_address
    : base_node_address + {4'h0, sw_val};

  // ID assignment frame acceptance
  wire id_frame_ok = frame_valid_i && (frame_cobid_i == ID_FRAME_COBID)
    && (frame_data_i[31:0] == 32'h0);
  wire id_accept = id_frame_ok && sw_zero && (sw_val == 4'h0)
    && !id_mode && !param_fault && !initialising;
  wire id_confirm = id_mode && press && !nmt_reset_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_node_address <= BASE_ADDR_RESET;
      default_node_address <= DEFAULT_ADDR_RESET;
      second_line_enable <= LINE2_RESET;
      bus_bit_rate_setting <= RATE_RESET;
      hist_sel <= 4'h0;
    end else begin
      if (wr_config) begin
        second_line_enable <= wb_dat_i[CFG_LINE2_BIT];
        if (wr_rate <= RATE_MAX) begin
          bus_bit_rate_setting <= wr_rate;
        end
      end
      if (wr_base) begin
        base_node_address <= wb_dat_i[7:0];
      end
      if (id_confirm) begin
        default_node_address <= pending_addr;
      end else if (wr_default) begin
        default_node_address <= wb_dat_i[7:0];
      end
      if (wr_hist_sel) begin
        hist_sel <= wb_dat_i[3:0];
      end
    end
  end

  // Operating state: init, parameter fault, ID mode, active error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      initialising <= 1'b1;
      param_fault <= 1'b0;
      id_mode <= 1'b0;
      pending_addr <= 8'h0;
      active_error <= 1'b0;
    end else begin
      if (initialising && pl_sync) begin
        initialising <= 1'b0;
        param_fault <= !pf_sync;
      end
      if (id_accept) begin
        id_mode <= 1'b1;
        pending_addr <= frame_data_i[39:32];
      end else if (id_confirm || nmt_reset_i) begin
        id_mode <= 1'b0;
      end
      if (event_valid_i && event_is_error_i) begin
        active_error <= 1'b1;
      end else if (nmt_reset_i) begin
        active_error <= 1'b0;
      end
    end
  end

  // Event history, newest at index zero
  logic [15:0] warn_hist [HIST_DEPTH];
  logic [15:0] err_hist [HIST_DEPTH];
  logic [2:0] warn_count;
  logic [2:0] err_count;
  wire new_warn = event_valid_i && !event_is_error_i;
  wire new_err = event_valid_i && event_is_error_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_count <= 3'h0;
      err_count <= 3'h0;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        warn_hist[i] <= 16'h0;
        err_hist[i] <= 16'h0;
      end
    end else begin
      if (new_warn) begin
        warn_count <= count_up(warn_count);
        warn_hist[0] <= event_code_i;
        for (int i = 1; i < HIST_DEPTH; i++) begin
          warn_hist[i] <= warn_hist[i - 1];
        end
      end
      if (new_err) begin
        err_count <= count_up(err_count);
        err_hist[0] <= event_code_i;
        for (int i = 1; i < HIST_DEPTH; i++) begin
          err_hist[i] <= err_hist[i - 1];
        end
      end
    end
  end

  // Display view sequencing
  nidsd_view_type view;
  logic [2:0] view_idx;
  wire [2:0] next_idx = view_idx + 3'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      view <= VIEW_ADDR;
      view_idx <= 3'h0;
    end else if (event_valid_i) begin
      view <= event_is_error_i ? VIEW_ERR : VIEW_WARN;
      view_idx <= 3'h0;
    end else if (hold_hit) begin
      view <= VIEW_ADDR;
      view_idx <= 3'h0;
    end else if (press && !id_mode) begin
      unique case (view)
        VIEW_ADDR: begin
          view <= VIEW_WARN;
          view_idx <= 3'h0;
        end
        VIEW_WARN: begin
          if (next_idx < warn_count) begin
            view_idx <= next_idx;
          end else begin
            view <= VIEW_ERR;
            view_idx <= 3'h0;
          end
        end
        VIEW_ERR: begin
          if (next_idx < err_count) begin
            view_idx <= next_idx;
          end else begin
            view <= VIEW_ADDR;
            view_idx <= 3'h0;
          end
        end
        default: begin
          view <= VIEW_ADDR;
          view_idx <= 3'h0;
        end
      endcase
    end
  end

  // Display content
  wire [15:0] warn_code = (view_idx < 3'(HIST_DEPTH)) ? warn_hist[view_idx] : 16'h0;
  wire [15:0] err_code = (view_idx < 3'(HIST_DEPTH)) ? err_hist[view_idx] : 16'h0;
  wire show_fault = param_fault;
  wire [15:0] next_digits = show_fault ? MISSING_PARAM_FILE_CODE
    : id_mode ? {4'h0, to_decimal(pending_addr)}
    : (view == VIEW_WARN) ? warn_code
    : (view == VIEW_ERR) ? err_code
    : {4'h0, to_decimal(node_address_o)};
  wire next_dot_warn = !show_fault && !id_mode && (view == VIEW_WARN);
  wire next_dot_err = show_fault || (!id_mode && (view == VIEW_ERR));
  wire next_blank = id_mode && blink;

  // Status indication
  wire next_run_red = active_error || param_fault;
  wire next_run_green = !next_run_red && (!initialising || blink);
  wire [1:0] line_on = {second_line_enable_o, 1'b1};
  wire [1:0] next_line_red = line_on & line_error_i;
  wire [1:0] next_line_green = line_on & ~line_error_i & line_activity_i
    & {2{blink}};
  wire next_comm = !id_mode && !param_fault && !initialising;

  // Register read mux
  wire [31:0] status_word = {8'h0, 1'b0, err_count, 1'b0, warn_count,
    second_line_enable_o, bus_bit_rate_o, initialising, active_error,
    param_fault, id_mode, node_address_o};
  wire [15:0] hist_word = (hist_sel < 4'(HIST_DEPTH)) ? warn_hist[hist_sel[2:0]]
    : (hist_sel < 4'(2 * HIST_DEPTH)) ? err_hist[3'(hist_sel - 4'(HIST_DEPTH))] : 16'h0;
  wire [31:0] rd_data = (wb_adr_i == REG_CONFIG) ?
      {25'h0, bus_bit_rate_setting, 3'h0, second_line_enable}
    : (wb_adr_i == REG_BASE_ADDR) ? {24'h0, base_node_address}
    : (wb_adr_i == REG_DEFAULT_ADDR) ? {24'h0, default_node_address}
    : (wb_adr_i == REG_STATUS) ? status_word
    : (wb_adr_i == REG_HIST_SEL) ? {28'h0, hist_sel}
    : (wb_adr_i == REG_HIST_DATA) ? {16'h0, hist_word}
    : 32'h0;

  // Wishbone answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0;
    end
  end
  assign wb_ack_o = wb_ack;

  // Bus settings take effect at restart only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_bit_rate_o <= RATE_500K;
      second_line_enable_o <= LINE2_RESET;
    end else if (nmt_reset_i) begin
      bus_bit_rate_o <= nidsd_rate_type'(bus_bit_rate_setting);
      second_line_enable_o <= second_line_enable;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      node_address_o <= DEFAULT_ADDR_RESET;
      bus_comm_enable_o <= 1'b0;
      id_setting_mode_o <= 1'b0;
      store_default_o <= 1'b0;
      store_default_addr_o <= 8'h0;
      emergency_o <= 1'b0;
      emergency_code_o <= 16'h0;
      nmt_preop_o <= 1'b0;
      run_led_green_o <= 1'b0;
      run_led_red_o <= 1'b0;
      line_led_green_o <= 2'h0;
      line_led_red_o <= 2'h0;
      seg_digits_o <= 16'h0;
      seg_blank_o <= 1'b1;
      seg_dot_warn_o <= 1'b0;
      seg_dot_err_o <= 1'b0;
    end else begin
      node_address_o <= next_node_address;
      bus_comm_enable_o <= next_comm;
      id_setting_mode_o <= id_mode;
      store_default_o <= id_confirm;
      store_default_addr_o <= id_confirm ? pending_addr : store_default_addr_o;
      emergency_o <= event_valid_i;
      emergency_code_o <= event_valid_i ? event_code_i : emergency_code_o;
      nmt_preop_o <= event_valid_i && event_preop_i;
      run_led_green_o <= next_run_green;
      run_led_red_o <= next_run_red;
      line_led_green_o <= next_line_green;
      line_led_red_o <= next_line_red;
      seg_digits_o <= next_digits;
      seg_blank_o <= next_blank;
      seg_dot_warn_o <= next_dot_warn;
      seg_dot_err_o <= next_dot_err;
    end
  end
endmodule

`default_nettype wire

// ===== tb/nidsd_assertions.sv
// Checker: port-level timing rules of the node ID and status display block
`timescale 1ns/1ps
`default_nettype none
module nidsd_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Inputs watched
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic event_valid_i,
  input wire logic event_is_error_i,
  input wire logic event_preop_i,
  input wire logic [15:0] event_code_i,
  input wire logic nmt_reset_i,
  input wire logic [1:0] line_error_i,
  // Outputs watched
  input wire logic wb_ack_o,
  input wire logic emergency_o,
  input wire logic [15:0] emergency_code_o,
  input wire logic nmt_preop_o,
  input wire logic run_led_red_o,
  input wire logic id_setting_mode_o,
  input wire logic bus_comm_enable_o,
  input wire logic store_default_o,
  input wire nidsd_pkg::nidsd_rate_type bus_bit_rate_o,
  input wire logic second_line_enable_o,
  input wire logic [1:0] line_led_green_o,
  input wire logic [1:0] line_led_red_o,
  input wire logic seg_dot_warn_o,
  input wire logic seg_dot_err_o
);
  import nidsd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");
  property p_emerg;
    event_valid_i |=> emergency_o && emergency_code_o == $past(event_code_i);
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency missing");
  property p_preop;
    event_valid_i && event_preop_i |=> nmt_preop_o;
  endproperty
  a_preop: assert property (p_preop) else $error("preop request missing");
  property p_red;
    event_valid_i && event_is_error_i |-> ##2 run_led_red_o;
  endproperty
  a_red: assert property (p_red) else $error("red led not lit");
  property p_silent;
    id_setting_mode_o |-> !bus_comm_enable_o;
  endproperty
  a_silent: assert property (p_silent) else $error("bus active in id mode");
  property p_nmt_exit;
    id_setting_mode_o && nmt_reset_i |-> ##[1:2] !id_setting_mode_o;
  endproperty
  a_nmt_exit: assert property (p_nmt_exit) else $error("id mode kept");
  property p_store;
    store_default_o |-> ($past(id_setting_mode_o) || $past(id_setting_mode_o, 2))
      ##1 !store_default_o;
  endproperty
  a_store: assert property (p_store) else $error("stray store pulse");
  property p_rate;
    !$stable(bus_bit_rate_o) |-> $past(nmt_reset_i) || $past(nmt_reset_i, 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate changed early");
  property p_dots;
    !(seg_dot_warn_o && seg_dot_err_o);
  endproperty
  a_dots: assert property (p_dots) else $error("both dots lit");
  property p_line2;
    !second_line_enable_o ##1 !second_line_enable_o |-> line_led_green_o[1] == 1'b0
      && line_led_red_o[1] == 1'b0;
  endproperty
  a_line2: assert property (p_line2) else $error("line two led lit");
  property p_line_err;
    line_error_i[0] |-> ##[1:2] line_led_red_o[0];
  endproperty
  a_line_err: assert property (p_line_err) else $error("line red missing");
endmodule
`default_nettype wire

// ===== tb/nidsd_busm.sv
// Model: bus master sending frames and network resets
`timescale 1ns/1ps
`default_nettype none
module nidsd_busm (
  // Clock
  input wire logic clk_i,
  // Frames and network management
  output logic frame_valid_o,
  output logic [10:0] frame_cobid_o,
  output logic [47:0] frame_data_o,
  output logic nmt_reset_o
);
  import nidsd_pkg::*;
  initial begin
    frame_valid_o = 1'b0;
    frame_cobid_o = 11'h000;
    frame_data_o = 48'h0;
    nmt_reset_o = 1'b0;
  end
  task automatic send_frame(input logic [10:0] cob, input logic [47:0] d);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    frame_cobid_o <= cob;
    frame_data_o <= d;
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    frame_cobid_o <= ~cob;
    frame_data_o <= ~d;
  endtask
  // Head must be zero for a proper frame
  task automatic send_id_frame(input logic [31:0] head, input logic [7:0] a);
    send_frame(ID_FRAME_COBID, {8'h00, a, head});
  endtask
  task automatic send_nmt();
    @(posedge clk_i);
    nmt_reset_o <= 1'b1;
    @(posedge clk_i);
    nmt_reset_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench: node ID and status display block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nidsd_pkg::*;
  localparam int DEB = 4;
  localparam int HOLD = 40;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, node_address_o, store_default_addr_o;
  logic [3:0] wb_sel_i = 4'h0, id_switch_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, button_i = 1'b0, param_file_present_i = 1'b1, param_load_done_i = 1'b0;
  logic event_valid_i = 1'b0, event_is_error_i = 1'b0, event_preop_i = 1'b0;
  logic [15:0] event_code_i = 16'h0000, emergency_code_o, seg_digits_o;
  logic [1:0] line_activity_i = 2'b00, line_error_i = 2'b00, line_led_green_o, line_led_red_o;
  logic frame_valid_i, nmt_reset_i, second_line_enable_o, bus_comm_enable_o;
  logic [10:0] frame_cobid_i;
  logic [47:0] frame_data_i;
  nidsd_rate_type bus_bit_rate_o;
  logic id_setting_mode_o, store_default_o, emergency_o, nmt_preop_o, run_led_green_o;
  logic run_led_red_o, seg_blank_o, seg_dot_warn_o, seg_dot_err_o, prev;
  int n_errors = 0, samples_checked = 0, cycles = 0, i, k;
  always #20 clk_i = ~clk_i;
  nidsd_top #(.DEBOUNCE_CYC(DEB), .HOLD_CYC(HOLD), .BLINK_CYC(3)) nidsd_top_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .id_switch_i, .button_i, .param_file_present_i,
    .param_load_done_i, .frame_valid_i, .frame_cobid_i, .frame_data_i, .nmt_reset_i,
    .event_valid_i, .event_is_error_i, .event_preop_i, .event_code_i, .line_activity_i,
    .line_error_i, .node_address_o, .bus_bit_rate_o, .second_line_enable_o,
    .bus_comm_enable_o, .id_setting_mode_o, .store_default_o, .store_default_addr_o,
    .emergency_o, .emergency_code_o, .nmt_preop_o, .run_led_green_o, .run_led_red_o,
    .line_led_green_o, .line_led_red_o, .seg_digits_o, .seg_blank_o, .seg_dot_warn_o,
    .seg_dot_err_o);
  nidsd_busm nidsd_busm_inst (.clk_i, .frame_valid_o(frame_valid_i),
    .frame_cobid_o(frame_cobid_i), .frame_data_o(frame_data_i), .nmt_reset_o(nmt_reset_i));
  task automatic results();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic press(input int n);
    @(posedge clk_i);
    button_i <= 1'b1;
    tick(n);
    button_i <= 1'b0;
    tick(DEB + 8);
  endtask
  task automatic ev(input logic err, input logic [15:0] code);
    @(posedge clk_i);
    event_valid_i <= 1'b1;
    event_is_error_i <= err;
    event_preop_i <= err;
    event_code_i <= code;
    @(posedge clk_i);
    event_valid_i <= 1'b0;
    tick(3);
  endtask
  initial begin
    tick(20);
    rst_i <= 1'b0;
    rd("base", REG_BASE_ADDR, 32'h64);
    rd("default", REG_DEFAULT_ADDR, 32'h64);
    rd("config", REG_CONFIG, 32'h31);
    rd("unmapped", 8'h20, 32'h0);
    k = 0;
    repeat (12) begin
      prev = run_led_green_o;
      @(posedge clk_i);
      if (run_led_green_o !== prev) k++;
    end
    chk("init_flash", 32'(k > 0), 32'h1);
    chk("init_comm", 32'h0, bus_comm_enable_o);
    param_load_done_i <= 1'b1;
    line_activity_i <= 2'b01;
    tick(8);
    repeat (3) begin
      tick(2);
      chk("run_green", 32'h1, run_led_green_o);
    end
    k = 0;
    repeat (12) begin
      prev = line_led_green_o[0];
      @(posedge clk_i);
      if (line_led_green_o[0] !== prev) k++;
    end
    chk("line1_flash", 32'(k > 0), 32'h1);
    for (i = 1; i <= 9; i++) begin
      id_switch_i <= 4'(i);
      tick(6);
      chk("addr_sw", 100 + i, node_address_o);
    end
    id_switch_i <= 4'h0;
    tick(6);
    chk("addr_sw0", 32'd100, node_address_o);
    for (i = 0; i <= 4; i++) begin
      wb(1'b1, REG_CONFIG, 32'(i * 16 + i % 2));
      tick(2);
      chk("rate_pend", (i == 0) ? 3 : i - 1, bus_bit_rate_o);
      nidsd_busm_inst.send_nmt();
      tick(3);
      chk("rate", i, bus_bit_rate_o);
      chk("line2", i % 2, second_line_enable_o);
    end
    wb(1'b1, REG_CONFIG, 32'h71);
    rd("rate_bad", REG_CONFIG, 32'h41);
    line_error_i <= 2'b11;
    tick(3);
    chk("line1_red", 32'h1, line_led_red_o[0]);
    chk("line2_off", 32'h0, line_led_red_o[1]);
    line_error_i <= 2'b00;
    id_switch_i <= 4'h5;
    tick(4);
    nidsd_busm_inst.send_id_frame(32'h0, 8'h2a);
    tick(3);
    chk("idm_sw5", 32'h0, id_setting_mode_o);
    id_switch_i <= 4'h0;
    tick(4);
    nidsd_busm_inst.send_id_frame(32'h0001_0000, 8'h2a);
    tick(3);
    chk("idm_bad", 32'h0, id_setting_mode_o);
    nidsd_busm_inst.send_id_frame(32'h0, 8'h2a);
    tick(3);
    chk("idm", 32'h1, id_setting_mode_o);
    chk("comm_id", 32'h0, bus_comm_enable_o);
    chk("digits_id", 32'h0042, seg_digits_o);
    k = 0;
    repeat (12) begin
      prev = seg_blank_o;
      @(posedge clk_i);
      if (seg_blank_o !== prev) k++;
    end
    chk("id_flash", 32'(k > 0), 32'h1);
    press(DEB + 6);
    chk("idm_done", 32'h0, id_setting_mode_o);
    chk("blank_off", 32'h0, seg_blank_o);
    chk("store_addr", 32'h2a, store_default_addr_o);
    chk("addr_new", 32'd42, node_address_o);
    rd("default_new", REG_DEFAULT_ADDR, 32'h2a);
    nidsd_busm_inst.send_id_frame(32'h0, 8'h33);
    tick(24);
    chk("idm_stay", 32'h1, id_setting_mode_o);
    nidsd_busm_inst.send_nmt();
    tick(3);
    chk("idm_nmt", 32'h0, id_setting_mode_o);
    rd("default_kept", REG_DEFAULT_ADDR, 32'h2a);
    ev(1'b0, 16'h1234);
    chk("warn_code", 32'h1234, seg_digits_o);
    chk("warn_dot", 32'h1, seg_dot_warn_o);
    ev(1'b1, 16'hbeef);
    chk("err_code", 32'hbeef, seg_digits_o);
    chk("err_dot", 32'h1, seg_dot_err_o);
    press(DEB + 6);
    chk("view_wrap", 32'h0042, seg_digits_o);
    press(HOLD + 20);
    chk("view_addr", 32'h0042, seg_digits_o);
    chk("addr_dots", 32'h0, {seg_dot_warn_o, seg_dot_err_o});
    wb(1'b0, REG_STATUS, 32'h0);
    chk("err_kept", 32'h1, q[ST_ACTIVE_ERR_BIT]);
    press(DEB + 6);
    chk("view_warn", 32'h1234, seg_digits_o);
    press(DEB + 6);
    chk("view_err", 32'hbeef, seg_digits_o);
    press(DEB + 6);
    chk("view_back", 32'h0042, seg_digits_o);
    nidsd_busm_inst.send_nmt();
    tick(3);
    chk("red_clr", 32'h0, run_led_red_o);
    for (i = 0; i < 7; i++) ev(1'b0, 16'h0100 + 16'(i));
    wb(1'b1, REG_HIST_SEL, 32'h0);
    rd("hist_new", REG_HIST_DATA, 32'h0106);
    wb(1'b1, REG_HIST_SEL, 32'h5);
    rd("hist_old", REG_HIST_DATA, 32'h0101);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("warn_cnt", 32'h6, q[18:16]);
    param_file_present_i <= 1'b0;
    rst_i <= 1'b1;
    tick(20);
    rst_i <= 1'b0;
    tick(10);
    chk("rate_restart", 32'h3, bus_bit_rate_o);
    chk("fault_code", 32'h0002, seg_digits_o);
    chk("fault_dot", 32'h1, seg_dot_err_o);
    chk("fault_comm", 32'h0, bus_comm_enable_o);
    results();
  end
endmodule
bind nidsd_top nidsd_assertions nidsd_assertions_inst (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .event_valid_i, .event_is_error_i, .event_preop_i, .event_code_i,
  .nmt_reset_i, .line_error_i, .wb_ack_o, .emergency_o, .emergency_code_o, .nmt_preop_o,
  .run_led_red_o, .id_setting_mode_o, .bus_comm_enable_o, .store_default_o,
  .bus_bit_rate_o, .second_line_enable_o, .line_led_green_o, .line_led_red_o,
  .seg_dot_warn_o, .seg_dot_err_o);
`default_nettype wire
